// *** verilog/utt_defs.svh ***
// Purpose: Constants of the user TAP tile
// Assumes: Included by the tile and its bench
// Notes:   Codes below 16 and above 127 belong to the tile itself
`ifndef UTT_DEFS_SVH
`define UTT_DEFS_SVH

`define UTT_IR_W        8
`define UTT_ID_W        32
`define UTT_SYNC_LEN    3
`define UTT_IR_BYPASS   8'hFF
`define UTT_IR_IDCODE   8'h0F
`define UTT_IR_CAPTURE  8'h01
`define UTT_USER_LO     8'h10
`define UTT_USER_HI     8'h7F
`define UTT_PIN_N       5
`define UTT_PIN_TCK     0
`define UTT_PIN_TMS     1
`define UTT_PIN_TDI     2
`define UTT_PIN_TRST    3
`define UTT_PIN_USO     4
`define UTT_ID_DEFAULT  32'h0000_0001

`endif

// *** verilog/utt_pkg.sv ***
// Purpose: Types of the user TAP tile
// Assumes: Nothing
// Notes:   Gray codes along the usual walk through the states
package utt_pkg;

  typedef enum logic [3:0] {
    UTT_TLR     = 4'h0,
    UTT_RTI     = 4'h1,
    UTT_SEL_DR  = 4'h3,
    UTT_CAP_DR  = 4'h2,
    UTT_SH_DR   = 4'h6,
    UTT_EX1_DR  = 4'h7,
    UTT_PSE_DR  = 4'h5,
    UTT_EX2_DR  = 4'h4,
    UTT_UPD_DR  = 4'hC,
    UTT_SEL_IR  = 4'hD,
    UTT_CAP_IR  = 4'hF,
    UTT_SH_IR   = 4'hE,
    UTT_EX1_IR  = 4'hA,
    UTT_PSE_IR  = 4'hB,
    UTT_EX2_IR  = 4'h9,
    UTT_UPD_IR  = 4'h8
  } utt_state_e;

  typedef logic [7:0] utt_ir_t;

endpackage

// *** verilog/utt_user_tap_tile.sv ***
// Purpose: Test access port controller with a user tile toward the core
// Assumes: Pins TCK, TMS, TDI, TRST_N and user serial out are asynchronous
//          to CLK and are sampled by it; TCK is far slower than CLK
// Notes:   Serial in and data-register clock are plain wires, not flops
// Behaviour
// R1: Instruction register shown whole on eight bits
// R2: Codes 16 to 127 left free for users
// R3: User reset low exactly in Test-Logic-Reset
// R4: Power-on reset forces Test-Logic-Reset
// R5: User reset held until host leaves reset
// R6: User serial in is TDI pin directly
// R7: User range routes user serial out to TDO
// R8: Shift strobe high exactly in Shift-DR
// R9: Capture strobe high exactly in Capture-DR
// R10: Data-register clock is TCK pin directly
// R11: Update strobe high exactly in Update-DR
// R12: Core treats tile pins as external, unbuffered
// R13: Core captures, shifts, drives low bit out
// R14: Core updates on strobe, clears in reset
`timescale 1ns/10ps
`include "utt_defs.svh"

module utt_user_tap_tile #(
  parameter logic [`UTT_ID_W-1:0] ID_CODE = `UTT_ID_DEFAULT // Arbitrary
) (
  input  wire logic              CLK,
  input  wire logic              NRST,
  input  wire logic              TCK,
  input  wire logic              TMS,
  input  wire logic              TDI,
  input  wire logic              TRST_N,
  output logic                   TDO,
  output logic                   TDO_OE,
  output utt_pkg::utt_ir_t       USER_INSTRUCTION_BUS,
  output logic                   TAP_RESET_OUT_N,
  output wire logic              USER_SERIAL_IN,
  input  wire logic              USER_SERIAL_OUT,
  output logic                   SHIFT_DR_STROBE,
  output logic                   CAPTURE_DR_STROBE,
  output wire logic              DR_TEST_CLOCK,
  output logic                   UPDATE_DR_STROBE
);
  import utt_pkg::*;

  // Decodes the instructions handed to the core
  function automatic logic is_user(input utt_ir_t code);
    is_user = (code >= `UTT_USER_LO) && (code <= `UTT_USER_HI); // R2
  endfunction

  logic [`UTT_PIN_N-1:0] pins;
  logic [`UTT_PIN_N-1:0] s1_ff, s2_ff, s3_ff, flt_ff;
  logic [`UTT_PIN_N-1:0] nxt_flt;

  assign pins = {USER_SERIAL_OUT, TRST_N, TDI, TMS, TCK};

  // Three stages; a pin change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `UTT_PIN_N; gi++) begin : g_sync
      always_comb begin
        nxt_flt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : flt_ff[gi];
      end
      always_ff @(posedge CLK) begin
        if (!NRST) begin
          s1_ff[gi]  <= 1'b0;
          s2_ff[gi]  <= 1'b0;
          s3_ff[gi]  <= 1'b0;
          flt_ff[gi] <= 1'b0;
        end else begin
          s1_ff[gi]  <= pins[gi];
          s2_ff[gi]  <= s1_ff[gi];
          s3_ff[gi]  <= s2_ff[gi];
          flt_ff[gi] <= nxt_flt[gi];
        end
      end
    end
  endgenerate

  logic tck_rise, tck_fall, tms_s, tdi_s, trst_s_n, uso_s;

  assign tck_rise = nxt_flt[`UTT_PIN_TCK] & ~flt_ff[`UTT_PIN_TCK];
  assign tck_fall = ~nxt_flt[`UTT_PIN_TCK] & flt_ff[`UTT_PIN_TCK];
  assign tms_s    = nxt_flt[`UTT_PIN_TMS];
  assign tdi_s    = nxt_flt[`UTT_PIN_TDI];
  assign trst_s_n = nxt_flt[`UTT_PIN_TRST];
  assign uso_s    = nxt_flt[`UTT_PIN_USO];

  // Straight wires: the core shifts on the real test clock
  assign USER_SERIAL_IN = TDI; // R6
  assign DR_TEST_CLOCK  = TCK; // R10

  utt_state_e state_ff, nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (!trst_s_n) begin
      nxt_state = UTT_TLR;
    end else if (tck_rise) begin
      case (state_ff)
        UTT_TLR:    nxt_state = tms_s ? UTT_TLR    : UTT_RTI; // R5
        UTT_RTI:    nxt_state = tms_s ? UTT_SEL_DR : UTT_RTI;
        UTT_SEL_DR: nxt_state = tms_s ? UTT_SEL_IR : UTT_CAP_DR;
        UTT_CAP_DR: nxt_state = tms_s ? UTT_EX1_DR : UTT_SH_DR;
        UTT_SH_DR:  nxt_state = tms_s ? UTT_EX1_DR : UTT_SH_DR;
        UTT_EX1_DR: nxt_state = tms_s ? UTT_UPD_DR : UTT_PSE_DR;
        UTT_PSE_DR: nxt_state = tms_s ? UTT_EX2_DR : UTT_PSE_DR;
        UTT_EX2_DR: nxt_state = tms_s ? UTT_UPD_DR : UTT_SH_DR;
        UTT_UPD_DR: nxt_state = tms_s ? UTT_SEL_DR : UTT_RTI;
        UTT_SEL_IR: nxt_state = tms_s ? UTT_TLR    : UTT_CAP_IR;
        UTT_CAP_IR: nxt_state = tms_s ? UTT_EX1_IR : UTT_SH_IR;
        UTT_SH_IR:  nxt_state = tms_s ? UTT_EX1_IR : UTT_SH_IR;
        UTT_EX1_IR: nxt_state = tms_s ? UTT_UPD_IR : UTT_PSE_IR;
        UTT_PSE_IR: nxt_state = tms_s ? UTT_EX2_IR : UTT_PSE_IR;
        UTT_EX2_IR: nxt_state = tms_s ? UTT_UPD_IR : UTT_SH_IR;
        UTT_UPD_IR: nxt_state = tms_s ? UTT_SEL_DR : UTT_RTI;
        default:    nxt_state = UTT_TLR;
      endcase
    end
  end

  // Strobes are registered from the next state so they match the state
  logic nxt_rst_n, nxt_shift, nxt_cap, nxt_upd;

  always_comb begin
    nxt_rst_n = (nxt_state != UTT_TLR);    // R3
    nxt_shift = (nxt_state == UTT_SH_DR);  // R8
    nxt_cap   = (nxt_state == UTT_CAP_DR); // R9
    nxt_upd   = (nxt_state == UTT_UPD_DR); // R11
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_ff          <= UTT_TLR; // R4
      TAP_RESET_OUT_N   <= 1'b0;    // R4
      SHIFT_DR_STROBE   <= 1'b0;
      CAPTURE_DR_STROBE <= 1'b0;
      UPDATE_DR_STROBE  <= 1'b0;
    end else begin
      state_ff          <= nxt_state;
      TAP_RESET_OUT_N   <= nxt_rst_n;
      SHIFT_DR_STROBE   <= nxt_shift;
      CAPTURE_DR_STROBE <= nxt_cap;
      UPDATE_DR_STROBE  <= nxt_upd;
    end
  end

  // Shift paths: instruction, identity, bypass
  utt_ir_t               ir_ff, ir_sh_ff, nxt_ir, nxt_ir_sh;
  logic [`UTT_ID_W-1:0]  id_sh_ff, nxt_id_sh;
  logic                  byp_ff, nxt_byp;
  logic                  nxt_tdo, nxt_oe;

  always_comb begin
    nxt_ir    = ir_ff;
    nxt_ir_sh = ir_sh_ff;
    nxt_id_sh = id_sh_ff;
    nxt_byp   = byp_ff;
    nxt_tdo   = TDO;
    nxt_oe    = TDO_OE;
    if (!trst_s_n) begin
      // Test reset may cut a scan short, so release the pin at once
      nxt_ir  = `UTT_IR_IDCODE;
      nxt_oe  = 1'b0;
      nxt_tdo = 1'b0;
    end else if (tck_rise) begin
      case (state_ff)
        UTT_TLR:    nxt_ir    = `UTT_IR_IDCODE;
        UTT_CAP_IR: nxt_ir_sh = `UTT_IR_CAPTURE;
        UTT_SH_IR:  nxt_ir_sh = {tdi_s, ir_sh_ff[`UTT_IR_W-1:1]};
        UTT_CAP_DR: begin
          nxt_id_sh = ID_CODE;
          nxt_byp   = 1'b0;
        end
        UTT_SH_DR: begin
          nxt_id_sh = {tdi_s, id_sh_ff[`UTT_ID_W-1:1]};
          nxt_byp   = tdi_s;
        end
        default: nxt_byp = byp_ff;
      endcase
    end else if (tck_fall) begin
      // Output changes on the falling edge so the host samples it stable
      nxt_oe  = 1'b0;
      nxt_tdo = 1'b0;
      case (state_ff)
        UTT_UPD_IR: nxt_ir = ir_sh_ff;
        UTT_SH_IR: begin
          nxt_oe  = 1'b1;
          nxt_tdo = ir_sh_ff[0];
        end
        UTT_SH_DR: begin
          nxt_oe = 1'b1;
          if (is_user(ir_ff)) begin
            nxt_tdo = uso_s; // R7
          end else if (ir_ff == `UTT_IR_IDCODE) begin
            nxt_tdo = id_sh_ff[0];
          end else begin
            nxt_tdo = byp_ff;
          end
        end
        default: nxt_oe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ir_ff    <= `UTT_IR_IDCODE;
      ir_sh_ff <= `UTT_IR_CAPTURE;
      id_sh_ff <= ID_CODE;
      byp_ff   <= 1'b0;
      TDO      <= 1'b0;
      TDO_OE   <= 1'b0;
    end else begin
      ir_ff    <= nxt_ir;
      ir_sh_ff <= nxt_ir_sh;
      id_sh_ff <= nxt_id_sh;
      byp_ff   <= nxt_byp;
      TDO      <= nxt_tdo;
      TDO_OE   <= nxt_oe;
    end
  end

  assign USER_INSTRUCTION_BUS = ir_ff; // R1

endmodule

// *** bench/utt_tile_sva.sv ***
// Purpose: Port checks of the user TAP tile
// Assumes: TCK far slower than CLK
// Notes:   Bound from the bench top file
`timescale 1ns/10ps
module utt_tile_sva (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic TCK,
  input wire logic TDI,
  input wire logic TRST_N,
  input wire logic TDO_OE,
  input wire logic TAP_RESET_OUT_N,
  input wire logic USER_SERIAL_IN,
  input wire logic SHIFT_DR_STROBE,
  input wire logic CAPTURE_DR_STROBE,
  input wire logic DR_TEST_CLOCK,
  input wire logic UPDATE_DR_STROBE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_serial_in_wire: assert property (USER_SERIAL_IN == TDI)
    else $error("serial in differs from data pin");
  a_dr_clock_wire: assert property (DR_TEST_CLOCK == TCK)
    else $error("data clock differs from test clock");
  a_reset_at_por: assert property ($rose(NRST) |-> !TAP_RESET_OUT_N)
    else $error("user reset not low after power-on");
  a_reset_by_trst: assert property (!TRST_N [*8] |-> !TAP_RESET_OUT_N)
    else $error("user reset high under test reset");
  a_leave_by_tck:
    assert property ($rose(TAP_RESET_OUT_N) |-> TCK && $past(TCK, 2))
    else $error("user reset left without a clock rise");
  a_strobe_onehot:
    assert property ($onehot0({SHIFT_DR_STROBE, CAPTURE_DR_STROBE,
                               UPDATE_DR_STROBE}))
    else $error("two state strobes high");
  a_reset_quiet:
    assert property (!TAP_RESET_OUT_N |-> !SHIFT_DR_STROBE &&
                     !CAPTURE_DR_STROBE && !UPDATE_DR_STROBE && !TDO_OE)
    else $error("activity in reset state");
  a_capture_stands:
    assert property ($rose(CAPTURE_DR_STROBE) |=> CAPTURE_DR_STROBE [*8])
    else $error("capture strobe too short");
  a_strobe_on_rise:
    assert property ($rose(SHIFT_DR_STROBE) || $rose(UPDATE_DR_STROBE) ||
                     $rose(CAPTURE_DR_STROBE) |-> TCK)
    else $error("strobe rose without a clock rise");
  a_oe_on_fall: assert property ($rose(TDO_OE) |-> !TCK)
    else $error("data out enabled while clock high");
  cover property ($rose(CAPTURE_DR_STROBE));
  cover property ($rose(UPDATE_DR_STROBE));
  cover property ($rose(TAP_RESET_OUT_N));
endmodule

// *** bench/utt_core_model.sv ***
// Purpose: User data register in the core behind the tile
// Assumes: Clocked straight from the tile's data clock
// Notes:   Drives the inverse bit when not selected
`timescale 1ns/10ps
`include "utt_defs.svh"
module utt_core_model #(
  parameter logic [7:0] CAPT = 8'hA5
) (
  input wire logic       dr_clk,
  input wire logic       rst_n,
  input wire logic [7:0] instr,
  input wire logic       cap,
  input wire logic       sh,
  input wire logic       upd,
  input wire logic       sin,
  output logic           sout,
  output logic [7:0]     hold
);
  logic [7:0] sh_ff;
  logic       mine;
  assign mine = instr >= `UTT_USER_LO && instr <= `UTT_USER_HI;
  assign sout = mine ? sh_ff[0] : ~sh_ff[0];
  always_ff @(posedge dr_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_ff <= 8'h00;
      hold  <= 8'h00;
    end else if (mine) begin
      if (cap) sh_ff <= CAPT;
      else if (sh) sh_ff <= {sin, sh_ff[7:1]};
      if (upd) hold <= sh_ff;
    end
  end
endmodule

// *** bench/utt_user_tap_tile_bench.sv ***
// Purpose: Drives the tile pins and checks its core side
// Assumes: TCK period 32 CLK, still between scans
// Notes:   Partner decodes the user range
`timescale 1ns/10ps
`include "utt_defs.svh"
module utt_user_tap_tile_bench;
  import utt_pkg::*;
  logic CLK = 0, NRST = 0, TCK = 0, TMS = 1, TDI = 0, TRST_N = 1;
  logic TDO, TDO_OE, TAP_RESET_OUT_N, USER_SERIAL_IN, USER_SERIAL_OUT;
  logic SHIFT_DR_STROBE, CAPTURE_DR_STROBE, DR_TEST_CLOCK, UPDATE_DR_STROBE;
  utt_ir_t USER_INSTRUCTION_BUS;
  logic [7:0] hold, dat, got, code, exp_hold;
  logic b;
  int mismatches = 0, compares = 0, seed = 67, cycles = 0;
  utt_user_tap_tile dut_u (.CLK, .NRST, .TCK, .TMS, .TDI, .TRST_N, .TDO,
    .TDO_OE, .USER_INSTRUCTION_BUS, .TAP_RESET_OUT_N, .USER_SERIAL_IN,
    .USER_SERIAL_OUT, .SHIFT_DR_STROBE, .CAPTURE_DR_STROBE, .DR_TEST_CLOCK,
    .UPDATE_DR_STROBE);
  utt_core_model core_u (.dr_clk(DR_TEST_CLOCK), .rst_n(TAP_RESET_OUT_N),
    .instr(USER_INSTRUCTION_BUS), .cap(CAPTURE_DR_STROBE), .hold(hold),
    .sh(SHIFT_DR_STROBE), .upd(UPDATE_DR_STROBE), .sin(USER_SERIAL_IN),
    .sout(USER_SERIAL_OUT));
  always #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  function automatic logic [7:0] exp_dr(input logic [7:0] c, v);
    if (c >= `UTT_USER_LO && c <= `UTT_USER_HI) return 8'hA5;
    if (c == `UTT_IR_IDCODE) return 8'(`UTT_ID_DEFAULT);
    return {v[6:0], 1'b0};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // TDO is taken just before the rise, after the previous fall settled
  task automatic tck(input logic ms, input logic di);
    TMS <= ms;
    TDI <= di;
    repeat (16) @(posedge CLK);
    b = TDO;
    TCK <= 1;
    repeat (16) @(posedge CLK);
    TCK <= 0;
  endtask
  task automatic scan(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      tck(i == 7, v[i]);
      got[i] = b;
    end
  endtask
  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    NRST <= 1;
    @(posedge CLK);
    check(TAP_RESET_OUT_N, 8'h00);
    check(USER_INSTRUCTION_BUS, `UTT_IR_IDCODE);
    for (int i = 0; i < 5; i++) tck(1, 0);
    check(TAP_RESET_OUT_N, 8'h00);
    tck(0, 0);
    check(TAP_RESET_OUT_N, 8'h01);
    exp_hold = 8'h00;
    for (int k = 0; k < 7; k++) begin
      code = k == 0 ? `UTT_USER_LO : k == 1 ? `UTT_USER_HI :
             k == 4 ? `UTT_IR_BYPASS : k == 5 ? `UTT_IR_IDCODE :
             k == 6 ? 8'h03 : 8'h10 + 8'($unsigned($random(seed)) % 112);
      tck(1, 0); tck(1, 0); tck(0, 0); tck(0, 0);
      scan(code);
      check(got, `UTT_IR_CAPTURE);
      tck(1, 0); tck(0, 0);
      check(USER_INSTRUCTION_BUS, code);
      dat = 8'($random(seed));
      tck(1, 0); tck(0, 0);
      check(CAPTURE_DR_STROBE, 8'h01);
      tck(0, 0);
      check(SHIFT_DR_STROBE, 8'h01);
      repeat (8) @(posedge CLK);
      check(TDO_OE, 8'h01);
      scan(dat);
      check(got, exp_dr(code, dat));
      tck(1, 0);
      check(UPDATE_DR_STROBE, 8'h01);
      tck(0, 0);
      if (code >= `UTT_USER_LO && code <= `UTT_USER_HI) exp_hold = dat;
      check(hold, exp_hold);
    end
    TRST_N <= 0;
    repeat (8) @(posedge CLK);
    check(TAP_RESET_OUT_N, 8'h00);
    check(hold, 8'h00);
    finish_test();
  end
endmodule
bind utt_user_tap_tile utt_tile_sva chk_u (.CLK, .NRST, .TCK, .TDI, .TRST_N,
  .TDO_OE, .TAP_RESET_OUT_N, .USER_SERIAL_IN, .SHIFT_DR_STROBE,
  .CAPTURE_DR_STROBE, .DR_TEST_CLOCK, .UPDATE_DR_STROBE);
